/* sim/ppvs_panel_model.sv */
`timescale 1ns/1ps
module ppvs_panel_model #(
  parameter int MSC = 40,
  parameter int HPD_MS = 3,
  parameter int TRAIN_CY = 20,
  parameter int SINK_MS = 2,
  parameter bit AUTO_BLACK = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic panel_logic_power,
  input wire logic hpd_mute,
  input wire logic aux_cap_req,
  input wire logic link_train_req,
  input wire logic video_valid,
  input wire logic no_video_flag,
  input wire logic backlight_enable_in,
  input wire logic backlight_dimming_in,
  output logic hpd,
  output logic aux_cap_ack,
  output logic link_train_done,
  output logic sink_status_valid,
  output logic black_video,
  output logic lit
);
  int pc;
  int tc;
  int vc;
  // ----------------------------------------
  // panel behaviour
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst || !panel_logic_power) begin
      pc <= 0;
      tc <= 0;
      vc <= 0;
      hpd <= 1'b0;
      aux_cap_ack <= 1'b0;
      link_train_done <= 1'b0;
      sink_status_valid <= 1'b0;
      black_video <= AUTO_BLACK;
      lit <= 1'b0;
    end else begin
      pc <= pc + 1;
      hpd <= hpd | (pc >= HPD_MS * MSC && !hpd_mute);
      aux_cap_ack <= hpd && aux_cap_req && !aux_cap_ack;
      tc <= link_train_req ? tc + 1 : 0;
      link_train_done <= link_train_req && tc >= TRAIN_CY;
      vc <= video_valid ? vc + 1 : 0;
      sink_status_valid <= video_valid && vc >= SINK_MS * MSC;
      black_video <= AUTO_BLACK && (!sink_status_valid || no_video_flag);
      lit <= backlight_enable_in && backlight_dimming_in;
    end
  end
endmodule : ppvs_panel_model

/* sim/tb_panel_power_video_sequencer.sv */
`timescale 1ns/1ps
module tb_panel_power_video_sequencer;
  import ppvs_pkg::*;
  localparam int MSC = 40;
  localparam logic [11:0] LIMS [4] = '{LINE_MIN, LINE_MAX, FRAME_MIN, FRAME_MAX};
  typedef struct {logic [31:0] e; logic [31:0] m; logic r;} ppvs_note_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hpd_mute = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, hpd, aux_cap_req, aux_cap_ack, link_train_req, link_train_done;
  logic link_idle, video_valid, no_video_flag, sink_status_valid, active_video_window;
  logic line_start, panel_logic_power, backlight_power_rail, backlight_dimming_in;
  logic backlight_enable_in, frame_start, bv, lit_s;
  logic [11:0] lr;
  logic [7:0] dr;
  int fails = 0, checks = 0, cyc = 1;
  int t_ar, t_tu, t_td, t_ru, t_rd, t_df, t_dl, t_eu, t_ed, t_vd, t_pu, t_pd;
  int lc, ac, ln_len, ln_act, fs_n = 0;
  ppvs_note_t notes[$];
  ppvs_note_t nt;
  always #12.5 clk = ~clk;
  ppvs_sequencer #(.MS_CYCLES(MSC), .PWM_DIV(2)) dut_u (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hpd, .aux_cap_req, .aux_cap_ack,
    .link_train_req, .link_train_done, .link_idle, .video_valid, .no_video_flag,
    .sink_status_valid, .active_video_window, .line_start, .frame_start,
    .panel_logic_power, .backlight_power_rail, .backlight_dimming_in, .backlight_enable_in);
  ppvs_panel_model #(.MSC(MSC)) panel_u (.clk, .nrst, .panel_logic_power, .hpd_mute,
    .aux_cap_req, .link_train_req, .video_valid, .no_video_flag, .backlight_enable_in,
    .backlight_dimming_in, .hpd, .aux_cap_ack, .link_train_done, .sink_status_valid,
    .black_video(bv), .lit(lit_s));
  // ----------------------------------------
  // event times and result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if ($rose(aux_cap_req)) t_ar <= cyc;
    if ($rose(link_train_req)) t_tu <= cyc;
    if ($fell(link_train_req)) t_td <= cyc;
    if ($rose(backlight_power_rail)) t_ru <= cyc;
    if ($fell(backlight_power_rail)) t_rd <= cyc;
    if (backlight_dimming_in && t_df <= t_ru) t_df <= cyc;
    if (backlight_dimming_in) t_dl <= cyc;
    if ($rose(backlight_enable_in)) t_eu <= cyc;
    if ($fell(backlight_enable_in)) t_ed <= cyc;
    if ($fell(video_valid)) t_vd <= cyc;
    if ($rose(panel_logic_power)) t_pu <= cyc;
    if ($fell(panel_logic_power)) t_pd <= cyc;
    lc <= line_start ? 1 : lc + 1;
    if (frame_start && line_start) fs_n <= fs_n + 1;
    ac <= line_start ? int'(active_video_window) : ac + int'(active_video_window);
    if (line_start) begin
      ln_len <= lc;
      ln_act <= ac;
    end
    if (psel && penable && pready && notes.size() > 0) begin
      nt = notes.pop_front();
      checks++;
      if ((prdata & nt.m) !== (nt.e & nt.m) || pslverr !== nt.r) begin
        fails++;
        $display("CHECK FAILED at %0t: read %h expected %h", $time, prdata, nt.e);
      end
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %0s", $time, msg);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic r);
    int n;
    n = 0;
    @(posedge clk);
    notes.push_back('{d, w ? 32'h0 : m, r});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(1'b0, "no ready");
      close_out();
    end
  endtask : apb
  task wait_state(input ppvs_state_t s, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, 32'h0, 1'b0);
      n++;
    end while (rd[13:0] !== s && n < lim);
    if (rd[13:0] !== s) begin
      chk(1'b0, "state wait");
      close_out();
    end
  endtask : wait_state
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    lr = 12'($urandom(32'h0c9d0b6f));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0, '1, 1'b0);
    apb(1'b0, REG_DIM, {24'h0, DIM_RESET}, '1, 1'b0);
    apb(1'b0, REG_LINE, {20'h0, LINE_TYP}, '1, 1'b0);
    apb(1'b0, REG_FRAME, {20'h0, FRAME_TYP}, '1, 1'b0);
    apb(1'b0, REG_STATUS, {18'h0, S_OFF}, 32'h001f3fff, 1'b0);
    apb(1'b0, 8'h20, 32'h0, '1, 1'b1);
    apb(1'b1, 8'h24, 32'h5, 32'h0, 1'b1);
    chk(no_video_flag === 1'b1 && panel_logic_power === 1'b0, "reset pins");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, i < 2 ? REG_LINE : REG_FRAME, i[0] ? 32'hfff : 32'h0, 32'h0, 1'b0);
      apb(1'b0, i < 2 ? REG_LINE : REG_FRAME, {20'h0, LIMS[i]}, 32'hfff, 1'b0);
    end
    lr = LINE_MIN + 12'($urandom_range(852));
    dr = 8'($urandom);
    apb(1'b1, REG_LINE, {20'h0, lr}, 32'h0, 1'b0);
    apb(1'b0, REG_LINE, {20'h0, lr}, 32'hfff, 1'b0);
    apb(1'b1, REG_DIM, {24'h0, dr}, 32'h0, 1'b0);
    apb(1'b0, REG_DIM, {24'h0, dr}, 32'hff, 1'b0);
    apb(1'b1, REG_DIM, 32'hff, 32'h0, 1'b0);
    $display("test limits done");
    apb(1'b1, REG_CTRL, 32'h1, 32'h0, 1'b0);
    wait_state(S_IDLE, 2000);
    chk(t_tu > t_ar && t_ar > t_pu, "link order");
    chk(t_td - t_tu >= MSC, "training length");
    apb(1'b0, REG_STATUS, {15'h0, 1'b1, 2'h0, S_IDLE}, 32'h001f3fff, 1'b0);
    chk(link_idle === 1'b1 && no_video_flag === 1'b1, "idle pins");
    chk(bv === 1'b1, "black before video");
    $display("test power up done");
    apb(1'b1, REG_CTRL, 32'h3, 32'h0, 1'b0);
    repeat (VALID_MAX_MS * MSC) @(posedge clk);
    apb(1'b0, REG_STATUS, {14'h0, 2'h3, 2'h0, S_VIDEO}, 32'h001f3fff, 1'b0);
    chk(video_valid === 1'b1 && no_video_flag === 1'b0, "video pins");
    chk(bv === 1'b0, "black not cleared");
    repeat (3 * 2910) @(posedge clk);
    chk(ln_len == int'(lr), "line length");
    chk(ln_act == int'(LINE_ACTIVE), "active clocks");
    chk(fs_n == 1, "frame start");
    $display("test video done");
    apb(1'b1, REG_CTRL, 32'h7, 32'h0, 1'b0);
    wait_state(S_BL_ON, 1000);
    repeat (2) @(posedge clk);
    chk(t_df - t_ru >= MSC, "dim after rail");
    chk(t_eu - t_df >= MSC && backlight_dimming_in === 1'b1, "enable after dim");
    chk(lit_s === 1'b1, "backlight not lit");
    $display("test backlight on done");
    apb(1'b1, REG_CTRL, 32'h1, 32'h0, 1'b0);
    wait_state(S_IDLE, 2000);
    chk(t_dl + 1 - t_ed >= MSC, "dim off after enable");
    chk(t_rd - t_dl - 1 >= MSC, "rail off after dim");
    chk(t_vd > t_rd && backlight_enable_in === 1'b0, "video end order");
    apb(1'b0, REG_STATUS, {15'h0, 1'b1, 2'h0, S_IDLE}, 32'h001f3fff, 1'b0);
    chk(no_video_flag === 1'b1, "no video flag");
    chk(bv === 1'b1, "black after video");
    apb(1'b1, REG_CTRL, 32'h0, 32'h0, 1'b0);
    wait_state(S_OFF, 10000);
    chk(t_pd > t_vd && t_pd - t_vd <= OFF_HOLD_MS * MSC, "power off time");
    $display("test shutdown done");
    hpd_mute <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1, 32'h0, 1'b0);
    wait_state(S_PWR_OFF, 5000);
    chk(t_pd - t_pu >= HPD_MAX_MS * MSC, "hot plug wait");
    apb(1'b0, REG_STATUS, 32'h00040000, 32'h00040000, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0, 32'h0, 1'b0);
    wait_state(S_OFF, 10000);
    apb(1'b1, REG_STATUS, 32'h00040000, 32'h0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0, 32'h00040000, 1'b0);
    $display("test hot plug timeout done");
    close_out();
  end
endmodule : tb_panel_power_video_sequencer

/* src/ppvs_ms_timer.sv */
`timescale 1ns/1ps
module ppvs_ms_timer #(
  parameter int MS_CYCLES = 40000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  output logic tick,
  output logic [9:0] ms
);
  // ----------------------------------------
  // cycle divider, restarted on clear
  // ----------------------------------------
  logic [31:0] div;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 32'h0;
      tick <= 1'b0;
    end else if (clear) begin
      div <= 32'h0;
      tick <= 1'b0;
    end else if (div == 32'(MS_CYCLES - 1)) begin
      div <= 32'h0;
      tick <= 1'b1;
    end else begin
      div <= div + 32'h1;
      tick <= 1'b0;
    end
  end

  // whole milliseconds since clear, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ms <= 10'h0;
    end else if (clear) begin
      ms <= 10'h0;
    end else if (tick && ms != 10'h3ff) begin
      ms <= ms + 10'h1;
    end
  end
endmodule : ppvs_ms_timer

/* src/ppvs_pkg.sv */
package ppvs_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [9:0] HPD_MAX_MS = 10'd200;
  localparam logic [9:0] AUX_MAX_MS = 10'd200;
  localparam logic [9:0] TRAIN_MIN_MS = 10'd1;
  localparam logic [9:0] VALID_MAX_MS = 10'd50;
  localparam logic [9:0] BL_GAP_MS = 10'd1;
  localparam logic [9:0] OFF_HOLD_MS = 10'd500;
  // ----------------------------------------
  // frame envelope
  // ----------------------------------------
  localparam logic [11:0] LINE_ACTIVE = 12'd1920;
  localparam logic [11:0] LINE_MIN = 12'd2058;
  localparam logic [11:0] LINE_TYP = 12'd2080;
  localparam logic [11:0] LINE_MAX = 12'd2910;
  localparam logic [11:0] FRAME_ACTIVE = 12'd1080;
  localparam logic [11:0] FRAME_MIN = 12'd1103;
  localparam logic [11:0] FRAME_TYP = 12'd1112;
  localparam logic [11:0] FRAME_MAX = 12'd1462;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIM = 8'h04;
  localparam logic [7:0] REG_LINE = 8'h08;
  localparam logic [7:0] REG_FRAME = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_VIDEO = 1;
  localparam int CTRL_BL = 2;
  localparam int ST_HPD = 16;
  localparam int ST_SINK = 17;
  localparam int ST_ERR_HPD = 18;
  localparam int ST_ERR_AUX = 19;
  localparam int ST_ERR_VALID = 20;
  localparam logic [7:0] DIM_RESET = 8'h80;
  typedef enum logic [13:0] {
    S_OFF = 14'h0001,
    S_PWR_UP = 14'h0002,
    S_CAP = 14'h0004,
    S_TRAIN = 14'h0008,
    S_IDLE = 14'h0010,
    S_VIDEO = 14'h0020,
    S_BL_RAIL = 14'h0040,
    S_BL_DIM = 14'h0080,
    S_BL_ON = 14'h0100,
    S_BL_EN_OFF = 14'h0200,
    S_BL_DIM_OFF = 14'h0400,
    S_VID_END = 14'h0800,
    S_PWR_OFF = 14'h1000,
    S_SPARE = 14'h2000
  } ppvs_state_t;
endpackage : ppvs_pkg

/* src/ppvs_sequencer.sv */
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// [R1] frame has 1080 active lines, total 1103 to 1462 lines
// [R2] vertical blanking is total lines minus active lines
// [R3] line has 1920 active clocks, total 2058 to 2910 clocks
// [R4] horizontal blanking is total clocks minus active clocks
// [R5] panel shows black video within 200 ms of logic power
// [R6] panel raises hot plug within 200 ms, aux already working
// [R7] after hot plug, source reads capability then starts training
// [R8] training lasts at least 1 ms
// [R9] after training, link idles before valid video
// [R10] panel validates video within 50 ms and sets sink status
// [R11] panel clears sink status when video ends, shows black
// [R12] backlight on only with stable video, off before video ends
// [R13] logic power removed within 500 ms of video end; the code drops it at once if CTRL_RUN is clear, else keeps it on in S_IDLE
// [R14] dimming applied at least 1 ms after backlight rail up
// [R15] backlight enable at least 1 ms after dimming applied
// [R16] dimming removed at least 1 ms after enable drops
// [R17] backlight rail dropped at least 1 ms after dimming removed
// [R18] panel blanks at power-on and on no-video-stream flag
// [R19] panel may offer a debug control disabling auto black
// [R20] aux polling after power-on is retried until answered; the code holds aux_cap_req up to AUX_MAX_MS, then sets the aux error
// [R21] enable switches converter, separate input carries dimming pwm
// [R22] panel shows black until valid video is validated
module ppvs_sequencer #(
  parameter int MS_CYCLES = ppvs_pkg::MS_CYCLES,
  parameter int PWM_DIV = 200
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hpd,
  output logic aux_cap_req,
  input wire logic aux_cap_ack,
  output logic link_train_req,
  input wire logic link_train_done,
  output logic link_idle,
  output logic video_valid,
  output logic no_video_flag,
  input wire logic sink_status_valid,
  output logic active_video_window,
  output logic line_start,
  output logic frame_start,
  output logic panel_logic_power,
  output logic backlight_power_rail,
  output logic backlight_dimming_in,
  output logic backlight_enable_in
);
  import ppvs_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo,
                                          input logic [11:0] hi);
    clamp12 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp12

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0] ctrl;
  logic [7:0] dim_duty;
  logic [11:0] line_total;
  logic [11:0] frame_total;
  logic [2:0] err;
  logic hpd_meta;
  logic hpd_s;
  ppvs_state_t state;
  ppvs_state_t next_state;
  logic tclear;
  logic [9:0] ms;
  logic wr;
  logic rd;
  logic mapped;
  logic set_err_hpd;
  logic set_err_aux;
  logic set_err_valid;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_DIM) || (paddr == REG_LINE) ||
                  (paddr == REG_FRAME) || (paddr == REG_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 3'h0;
      dim_duty <= DIM_RESET;
      line_total <= LINE_TYP;
      frame_total <= FRAME_TYP;
    end else if (wr) begin
      case (paddr)
        REG_CTRL: ctrl <= pwdata[2:0];
        REG_DIM: dim_duty <= pwdata[7:0];
        REG_LINE: line_total <= clamp12(pwdata[11:0], LINE_MIN, LINE_MAX); // [R3]
        REG_FRAME: frame_total <= clamp12(pwdata[11:0], FRAME_MIN, FRAME_MAX); // [R1]
        default: ;
      endcase
    end
  end

  // sticky errors, set wins over write-one-to-clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err <= 3'h0;
    end else begin
      err <= (err & ~((wr && paddr == REG_STATUS) ? pwdata[ST_ERR_VALID:ST_ERR_HPD] : 3'h0))
             | {set_err_valid, set_err_aux, set_err_hpd};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL: prdata <= {29'h0, ctrl};
        REG_DIM: prdata <= {24'h0, dim_duty};
        REG_LINE: prdata <= {20'h0, line_total};
        REG_FRAME: prdata <= {20'h0, frame_total};
        REG_STATUS: prdata <= {11'h0, err, sink_status_valid, hpd_s, 2'h0, state};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // hot plug synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hpd_meta <= 1'b0;
      hpd_s <= 1'b0;
    end else begin
      hpd_meta <= hpd;
      hpd_s <= hpd_meta;
    end
  end

  // ----------------------------------------
  // millisecond timer, restarted per state
  // ----------------------------------------
  assign tclear = (next_state != state);

  ppvs_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .clear(tclear),
    .tick(),
    .ms(ms)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    set_err_hpd = 1'b0;
    set_err_aux = 1'b0;
    set_err_valid = 1'b0;
    case (state)
      S_OFF: begin
        if (ctrl[CTRL_RUN]) next_state = S_PWR_UP;
      end
      S_PWR_UP: begin
        if (hpd_s) begin
          next_state = S_CAP; // [R7]
        end else if (ms >= HPD_MAX_MS || !ctrl[CTRL_RUN]) begin
          set_err_hpd = ctrl[CTRL_RUN]; // [R6]
          next_state = S_PWR_OFF;
        end
      end
      S_CAP: begin
        if (aux_cap_ack) begin
          next_state = S_TRAIN; // [R7]
        end else if (ms >= AUX_MAX_MS || !ctrl[CTRL_RUN]) begin
          set_err_aux = ctrl[CTRL_RUN]; // [R20]
          next_state = S_PWR_OFF;
        end
      end
      S_TRAIN: begin
        if (link_train_done && ms >= TRAIN_MIN_MS) next_state = S_IDLE; // [R8]
      end
      S_IDLE: begin
        if (!ctrl[CTRL_RUN]) next_state = S_PWR_OFF;
        else if (ctrl[CTRL_VIDEO]) next_state = S_VIDEO; // [R9]
      end
      S_VIDEO: begin
        if (!ctrl[CTRL_RUN] || !ctrl[CTRL_VIDEO]) begin
          next_state = S_VID_END;
        end else if (!sink_status_valid && ms == VALID_MAX_MS) begin
          set_err_valid = 1'b1; // [R10]
        end else if (sink_status_valid && ctrl[CTRL_BL]) begin
          next_state = S_BL_RAIL; // [R12]
        end
      end
      S_BL_RAIL: begin
        if (ms >= BL_GAP_MS) next_state = S_BL_DIM; // [R14]
      end
      S_BL_DIM: begin
        if (ms >= BL_GAP_MS) next_state = S_BL_ON; // [R15]
      end
      S_BL_ON: begin
        if (!ctrl[CTRL_BL] || !ctrl[CTRL_VIDEO] || !ctrl[CTRL_RUN] || !sink_status_valid) begin
          next_state = S_BL_EN_OFF; // [R12]
        end
      end
      S_BL_EN_OFF: begin
        if (ms >= BL_GAP_MS) next_state = S_BL_DIM_OFF; // [R16]
      end
      S_BL_DIM_OFF: begin
        if (ms >= BL_GAP_MS) next_state = S_VIDEO; // [R17]
      end
      S_VID_END: begin
        next_state = ctrl[CTRL_RUN] ? S_IDLE : S_PWR_OFF; // [R13]
      end
      S_PWR_OFF: begin
        if (ms >= OFF_HOLD_MS && !ctrl[CTRL_RUN]) next_state = S_OFF;
      end
      default: next_state = S_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // pin and link outputs
  // ----------------------------------------
  logic vid_on;
  logic bl_rail_on;
  logic bl_dim_on;
  logic [15:0] pwm_pre;
  logic [7:0] pwm_cnt;

  assign vid_on = (state == S_VIDEO) || (state == S_BL_RAIL) || (state == S_BL_DIM) ||
                  (state == S_BL_ON) || (state == S_BL_EN_OFF) || (state == S_BL_DIM_OFF);
  assign bl_rail_on = (state == S_BL_RAIL) || (state == S_BL_DIM) || (state == S_BL_ON) ||
                      (state == S_BL_EN_OFF) || (state == S_BL_DIM_OFF);
  assign bl_dim_on = (state == S_BL_DIM) || (state == S_BL_ON) || (state == S_BL_EN_OFF);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      panel_logic_power <= 1'b0;
      aux_cap_req <= 1'b0;
      link_train_req <= 1'b0;
      link_idle <= 1'b0;
      video_valid <= 1'b0;
      no_video_flag <= 1'b1;
      backlight_power_rail <= 1'b0;
      backlight_enable_in <= 1'b0;
    end else begin
      panel_logic_power <= (next_state != S_OFF) && (next_state != S_PWR_OFF);
      aux_cap_req <= (next_state == S_CAP); // [R20]
      link_train_req <= (next_state == S_TRAIN); // [R7]
      link_idle <= (next_state == S_IDLE) || (next_state == S_VID_END); // [R9]
      video_valid <= vid_on;
      no_video_flag <= !vid_on; // [R18]
      backlight_power_rail <= bl_rail_on;
      backlight_enable_in <= (state == S_BL_ON); // [R21]
    end
  end

  // dimming pwm, low whenever the dimming phase is off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_pre <= 16'h0;
      pwm_cnt <= 8'h0;
      backlight_dimming_in <= 1'b0;
    end else begin
      if (pwm_pre == 16'(PWM_DIV - 1)) begin
        pwm_pre <= 16'h0;
        pwm_cnt <= pwm_cnt + 8'h1;
      end else begin
        pwm_pre <= pwm_pre + 16'h1;
      end
      backlight_dimming_in <= bl_dim_on && (pwm_cnt < dim_duty || dim_duty == 8'hff); // [R21]
    end
  end

  // ----------------------------------------
  // frame timing generator
  // ----------------------------------------
  logic [11:0] hcnt;
  logic [11:0] vcnt;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hcnt <= 12'h0;
      vcnt <= 12'h0;
    end else if (!vid_on) begin
      hcnt <= 12'h0;
      vcnt <= 12'h0;
    end else if (hcnt == line_total - 12'h1) begin
      hcnt <= 12'h0; // [R4]
      vcnt <= (vcnt == frame_total - 12'h1) ? 12'h0 : vcnt + 12'h1; // [R2]
    end else begin
      hcnt <= hcnt + 12'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_video_window <= 1'b0;
      line_start <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      active_video_window <= vid_on && hcnt < LINE_ACTIVE && vcnt < FRAME_ACTIVE; // [R1] [R3]
      line_start <= vid_on && hcnt == 12'h0;
      frame_start <= vid_on && hcnt == 12'h0 && vcnt == 12'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_line_bounds: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    line_total >= LINE_MIN && line_total <= LINE_MAX)
    else $error("line total out of range");
  chk_frame_bounds: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    frame_total >= FRAME_MIN && frame_total <= FRAME_MAX)
    else $error("frame total out of range");
  chk_hblank_gap: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (hcnt >= LINE_ACTIVE) |=> !active_video_window)
    else $error("active window during line blanking");
  chk_vblank_gap: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    (vcnt >= FRAME_ACTIVE) |=> !active_video_window)
    else $error("active window during frame blanking");
  chk_train_min: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    (state == S_TRAIN && next_state == S_IDLE) |-> ms >= TRAIN_MIN_MS)
    else $error("training ended too early");
  chk_idle_before: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    $rose(video_valid) |-> $past(link_idle, 2))
    else $error("video without idle link");
  chk_bl_video: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    backlight_enable_in |-> video_valid && sink_status_valid)
    else $error("backlight on without stable video");
  chk_rail_dim: assert property (@(posedge clk) disable iff (!nrst) // [R14]
    (state == S_BL_RAIL && next_state == S_BL_DIM) |-> ms >= BL_GAP_MS)
    else $error("dimming too soon after rail");
  chk_dim_en: assert property (@(posedge clk) disable iff (!nrst) // [R15]
    $rose(backlight_enable_in) |-> $past(state) == S_BL_ON && $past(ms, 2) >= BL_GAP_MS)
    else $error("enable too soon after dimming");
  chk_en_dim_off: assert property (@(posedge clk) disable iff (!nrst) // [R16]
    (state == S_BL_EN_OFF && next_state == S_BL_DIM_OFF) |-> ms >= BL_GAP_MS)
    else $error("dimming removed too soon");
  chk_dim_rail_off: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    (state == S_BL_DIM_OFF && next_state == S_VIDEO) |-> ms >= BL_GAP_MS)
    else $error("rail dropped too soon");
  chk_off_prompt: assert property (@(posedge clk) disable iff (!nrst) // [R13]
    (state == S_VID_END && !ctrl[CTRL_RUN]) |-> ##[1:2] !panel_logic_power)
    else $error("logic power kept after video end");
endmodule : ppvs_sequencer
